/* src/hkf_params.svh */
// offsets, reset values, command codes and timing counts of the command handler
`ifndef HKF_PARAMS_SVH
`define HKF_PARAMS_SVH
`define HKF_OFS_CMD 8'h00
`define HKF_OFS_DATA 8'h04
`define HKF_OFS_CTRL 8'h08
`define HKF_OFS_RESP 8'h0C
`define HKF_OFS_RDATA0 8'h10
`define HKF_OFS_RDATA1 8'h14
`define HKF_OFS_KEYEVT 8'h18
`define HKF_CMD_STORE 8'h04
`define HKF_CMD_FANPWR 8'h11
`define HKF_CMD_LCD 8'h16
`define HKF_CMD_KEYCFG 8'h17
`define HKF_CMD_POLL 8'h18
`define HKF_CMD_FAILSAFE 8'h19
`define HKF_CMD_GLITCH 8'h1A
`define HKF_CMD_FANQRY 8'h1B
`define HKF_CMD_ATX 8'h1C
`define HKF_RESP_OK 8'h40
`define HKF_RESP_ERR 8'hC0
`define HKF_RST_KEYMASK 6'h3F
`define HKF_RST_GLITCH 8'h01
`define HKF_RST_ATXLEN 8'h20
`define HKF_FAN_MAX 8'h64
`define HKF_LCD_LOC_MAX 8'h02
`define HKF_BIT_RST_INV 1
`define HKF_BIT_PWR_INV 2
`define HKF_PWM_STEPS 7'h64
`define HKF_CLK_NS 50
`define HKF_STEP_NS 552500
`define HKF_TICK8_NS 125000000
`define HKF_TICK32_NS 31250000
`define HKF_STEP_CYC (`HKF_STEP_NS / `HKF_CLK_NS)
`define HKF_TICK8_CYC (`HKF_TICK8_NS / `HKF_CLK_NS)
`define HKF_TICK32_CYC (`HKF_TICK32_NS / `HKF_CLK_NS)
`endif

/* src/hkf_pkg.sv */
// types shared by the command handler
package hkf_pkg;
	typedef struct packed {
		logic [7:0] ctype;
		logic [4:0] clen;
		logic [3:0][7:0] d;
	} hkf_cmd_t;
	typedef struct packed {
		logic [7:0] rtype;
		logic [4:0] rlen;
		logic [4:0][7:0] rd;
	} hkf_resp_t;
endpackage

/* src/hkf_top.sv */
// host command handler for keypad, fans, display controller and power lines
`timescale 1ns/1ps
`include "hkf_params.svh"
// Notes on behaviour
// - command 0x16 writes byte two to data, control, or extended control.
// - each accepted answer type is command code ORed with 0x40, a rejected one ORed with 0xC0; set commands return no data.
// - after reset every key press and release is reported.
// - command 0x17 sets per-key press and release report masks.
// - key masks are kept in the boot state and restored at power-up.
// - poll command 0x18 returns held, pressed-since and released-since keys.
// - poll results ignore the report masks.
// - command 0x19 sets fail-safe fan mask and timeout in eighth seconds, 1 to 255.
// - on timeout without fan update, fail-safe fans go to full power.
// - fans are driven by roughly 18 Hz pulse-width modulation.
// - after fan turn-on, tach edges are ignored for the fan's delay count.
// - every glitch delay resets to one count.
// - command 0x1A sets four glitch delays, kept in the boot state.
// - command 0x1B returns four fan powers and the fail-safe mask.
// - power switch settings are kept in the boot state.
// - reset and power lines idle undriven and are pulsed to their active level.
// - mask bit 0x02 inverts reset, bit 0x04 inverts power control.
module hkf_top #(
	parameter int STEP_CYC = `HKF_STEP_CYC,
	parameter int TICK8_CYC = `HKF_TICK8_CYC,
	parameter int TICK32_CYC = `HKF_TICK32_CYC
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [5:0] key_in,
	input wire logic reboot,
	input wire logic [3:0] tach_in,
	output logic lcd_wr,
	output logic [1:0] lcd_sel,
	output logic [7:0] lcd_data,
	output logic [3:0] fan_pwm,
	output logic [3:0] tach_ok,
	input wire logic atx_rst_i,
	output logic atx_rst_o,
	output logic atx_rst_oe,
	input wire logic atx_pwr_i,
	output logic atx_pwr_o,
	output logic atx_pwr_oe
);
	if (STEP_CYC < 1 || TICK8_CYC < 1 || TICK32_CYC < 1) begin : g_chk
		$error("hkf_top: cycle counts must be at least one");
	end
	hkf_pkg::hkf_cmd_t cmd;
	hkf_pkg::hkf_resp_t resp;
	hkf_pkg::hkf_resp_t next_resp;
	logic done, next_ok, next_poll, next_fanupd;
	logic [5:0] press_mask, rel_mask, boot_press, boot_rel;
	logic [5:0] key_prev, poll_press, poll_rel, evt_press, evt_rel;
	logic [3:0][7:0] fan_power, glitch, boot_glitch, blank;
	logic [3:0] fs_mask, forced, pwm_on;
	logic [7:0] fs_timeout, fs_ticks, atx_mask, atx_len, boot_atx_mask, boot_atx_len, atx_cnt;
	logic fs_force;
	logic [31:0] step_cnt, t8_cnt, t32_cnt;
	logic [6:0] phase;
	logic acc, wr, go, evt_clr, step_end, t8_end, t32_end;
	logic [5:0] press_ev, rel_ev;

	assign acc = psel && penable && pready;
	assign wr = acc && pwrite;
	assign go = wr && paddr == `HKF_OFS_CTRL && pwdata[0];
	assign evt_clr = acc && !pwrite && paddr == `HKF_OFS_KEYEVT;
	assign press_ev = key_in & ~key_prev;
	assign rel_ev = key_prev & ~key_in;

	// one wait state: read data and error are taken in the same edge as pready
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			if (psel && penable && !pready) begin
				case (paddr)
					`HKF_OFS_CMD: prdata <= {19'h0, cmd.clen, cmd.ctype};
					`HKF_OFS_DATA: prdata <= cmd.d;
					`HKF_OFS_CTRL: prdata <= {27'h0, atx_pwr_i, atx_rst_i,
						atx_pwr_oe, atx_rst_oe, done};
					`HKF_OFS_RESP: prdata <= {19'h0, resp.rlen, resp.rtype};
					`HKF_OFS_RDATA0: prdata <= resp.rd[3:0];
					`HKF_OFS_RDATA1: prdata <= {24'h0, resp.rd[4]};
					`HKF_OFS_KEYEVT: prdata <= {18'h0, evt_rel, 2'h0, evt_press};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			cmd <= '0;
		end else if (wr && paddr == `HKF_OFS_CMD) begin
			cmd.ctype <= pwdata[7:0];
			cmd.clen <= pwdata[12:8];
		end else if (wr && paddr == `HKF_OFS_DATA) begin
			cmd.d <= pwdata;
		end
	end

	// validity check and answer of the pending command
	always_comb begin
		next_ok = 1'b0;
		next_poll = 1'b0;
		next_fanupd = 1'b0;
		next_resp = '0;
		case (cmd.ctype)
			`HKF_CMD_STORE: next_ok = cmd.clen == 5'h00;
			`HKF_CMD_FANPWR: begin
				next_ok = cmd.clen == 5'h04 && cmd.d[0] <= `HKF_FAN_MAX &&
					cmd.d[1] <= `HKF_FAN_MAX && cmd.d[2] <= `HKF_FAN_MAX &&
					cmd.d[3] <= `HKF_FAN_MAX;
				next_fanupd = next_ok;
			end
			`HKF_CMD_LCD: next_ok = cmd.clen == 5'h02 && cmd.d[0] <= `HKF_LCD_LOC_MAX;
			`HKF_CMD_KEYCFG: next_ok = cmd.clen == 5'h02;
			`HKF_CMD_POLL: begin
				next_ok = cmd.clen == 5'h00;
				next_poll = next_ok;
				next_resp.rlen = 5'h03;
				next_resp.rd[0] = {2'h0, key_in};
				next_resp.rd[1] = {2'h0, poll_press | press_ev};
				next_resp.rd[2] = {2'h0, poll_rel | rel_ev};
			end
			`HKF_CMD_FAILSAFE: next_ok = cmd.clen == 5'h02 && cmd.d[1] != 8'h00 &&
				cmd.d[0][7:4] == 4'h0;
			`HKF_CMD_GLITCH: next_ok = cmd.clen == 5'h04;
			`HKF_CMD_FANQRY: begin
				next_ok = cmd.clen == 5'h00;
				next_resp.rlen = 5'h05;
				next_resp.rd[3:0] = fan_power;
				next_resp.rd[4] = {4'h0, fs_mask};
			end
			`HKF_CMD_ATX: next_ok = cmd.clen == 5'h01 || cmd.clen == 5'h02;
			default: next_ok = 1'b0;
		endcase
		if (!next_ok) begin
			next_resp = '0;
		end
		next_resp.rtype = cmd.ctype | (next_ok ? `HKF_RESP_OK : `HKF_RESP_ERR);
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			resp <= '0;
			done <= 1'b0;
		end else begin
			if (go) begin
				resp <= next_resp;
			end
			done <= go || (done && !(wr && paddr == `HKF_OFS_CMD));
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			lcd_wr <= 1'b0;
			lcd_sel <= 2'h0;
			lcd_data <= 8'h0;
		end else begin
			lcd_wr <= go && next_ok && cmd.ctype == `HKF_CMD_LCD;
			if (go && next_ok && cmd.ctype == `HKF_CMD_LCD) begin
				lcd_sel <= cmd.d[0][1:0];
				lcd_data <= cmd.d[1];
			end
		end
	end

	// live settings, boot copies, reload on reboot
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			press_mask <= `HKF_RST_KEYMASK;
			rel_mask <= `HKF_RST_KEYMASK;
			glitch <= {4{`HKF_RST_GLITCH}};
			atx_mask <= 8'h00;
			atx_len <= `HKF_RST_ATXLEN;
			boot_press <= `HKF_RST_KEYMASK;
			boot_rel <= `HKF_RST_KEYMASK;
			boot_glitch <= {4{`HKF_RST_GLITCH}};
			boot_atx_mask <= 8'h00;
			boot_atx_len <= `HKF_RST_ATXLEN;
		end else if (reboot) begin
			press_mask <= boot_press;
			rel_mask <= boot_rel;
			glitch <= boot_glitch;
			atx_mask <= boot_atx_mask;
			atx_len <= boot_atx_len;
		end else if (go && next_ok) begin
			case (cmd.ctype)
				`HKF_CMD_STORE: begin
					boot_press <= press_mask;
					boot_rel <= rel_mask;
					boot_glitch <= glitch;
					boot_atx_mask <= atx_mask;
					boot_atx_len <= atx_len;
				end
				`HKF_CMD_KEYCFG: begin
					press_mask <= cmd.d[0][5:0];
					rel_mask <= cmd.d[1][5:0];
				end
				`HKF_CMD_GLITCH: glitch <= cmd.d;
				`HKF_CMD_ATX: begin
					atx_mask <= cmd.d[0];
					if (cmd.clen == 5'h02 && cmd.d[1] != 8'h00) begin
						atx_len <= cmd.d[1];
					end
				end
				default: atx_mask <= atx_mask;
			endcase
		end
	end

	// key flags: a new event wins over a clear in the same cycle
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			key_prev <= 6'h00;
			poll_press <= 6'h00;
			poll_rel <= 6'h00;
			evt_press <= 6'h00;
			evt_rel <= 6'h00;
		end else begin
			key_prev <= key_in;
			poll_press <= (go && next_poll ? 6'h00 : poll_press) | press_ev;
			poll_rel <= (go && next_poll ? 6'h00 : poll_rel) | rel_ev;
			evt_press <= (evt_clr ? 6'h00 : evt_press) | (press_ev & press_mask);
			evt_rel <= (evt_clr ? 6'h00 : evt_rel) | (rel_ev & rel_mask);
		end
	end

	// fan power and fail-safe timer
	assign t8_end = t8_cnt == TICK8_CYC - 1;
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			fan_power <= '0;
			fs_mask <= 4'h0;
			fs_timeout <= 8'h00;
			fs_ticks <= 8'h00;
			fs_force <= 1'b0;
			t8_cnt <= 32'h0;
		end else begin
			t8_cnt <= t8_end ? 32'h0 : t8_cnt + 32'h1;
			if (go && next_fanupd) begin
				fan_power <= cmd.d;
				fs_ticks <= 8'h00;
				fs_force <= 1'b0;
			end else if (go && next_ok && cmd.ctype == `HKF_CMD_FAILSAFE) begin
				fs_mask <= cmd.d[0][3:0];
				fs_timeout <= cmd.d[1];
				fs_ticks <= 8'h00;
				fs_force <= 1'b0;
			end else if (t8_end && fs_timeout != 8'h00 && !fs_force) begin
				fs_ticks <= fs_ticks + 8'h01;
				fs_force <= fs_ticks + 8'h01 >= fs_timeout;
			end
		end
	end
	assign forced = fs_mask & {4{fs_force}};

	// modulation: one period is a hundred glitch-count steps
	assign step_end = step_cnt == STEP_CYC - 1;
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			step_cnt <= 32'h0;
			phase <= 7'h00;
		end else begin
			step_cnt <= step_end ? 32'h0 : step_cnt + 32'h1;
			if (step_end) begin
				phase <= phase == `HKF_PWM_STEPS - 7'h01 ? 7'h00 : phase + 7'h01;
			end
		end
	end

	for (genvar i = 0; i < 4; i++) begin : g_fan
		assign pwm_on[i] = forced[i] || {1'b0, phase} < fan_power[i];
		always_ff @(posedge clk_sys) begin
			if (!nrst) begin
				fan_pwm[i] <= 1'b0;
				blank[i] <= 8'h00;
				tach_ok[i] <= 1'b0;
			end else begin
				fan_pwm[i] <= pwm_on[i];
				if (pwm_on[i] && !fan_pwm[i]) begin
					blank[i] <= glitch[i];
				end else if (step_end && blank[i] != 8'h00) begin
					blank[i] <= blank[i] - 8'h01;
				end
				tach_ok[i] <= fan_pwm[i] && blank[i] == 8'h00 && tach_in[i];
			end
		end
	end

	// power and reset pulses, length in 1/32 s ticks
	assign t32_end = t32_cnt == TICK32_CYC - 1;
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			t32_cnt <= 32'h0;
			atx_cnt <= 8'h00;
			atx_rst_oe <= 1'b0;
			atx_pwr_oe <= 1'b0;
			atx_rst_o <= 1'b0;
			atx_pwr_o <= 1'b0;
		end else if (wr && paddr == `HKF_OFS_CTRL && pwdata[2:1] != 2'h0) begin
			t32_cnt <= 32'h0;
			atx_cnt <= atx_len;
			atx_rst_oe <= pwdata[1];
			atx_pwr_oe <= pwdata[2];
			atx_rst_o <= atx_mask[`HKF_BIT_RST_INV];
			atx_pwr_o <= atx_mask[`HKF_BIT_PWR_INV];
		end else begin
			t32_cnt <= t32_end ? 32'h0 : t32_cnt + 32'h1;
			if (t32_end && atx_cnt != 8'h00) begin
				atx_cnt <= atx_cnt - 8'h01;
				if (atx_cnt == 8'h01) begin
					atx_rst_oe <= 1'b0;
					atx_pwr_oe <= 1'b0;
				end
			end
		end
	end

	property p_lcd;
		@(posedge clk_sys) disable iff (!nrst)
		go && next_ok && cmd.ctype == `HKF_CMD_LCD |=> lcd_wr && lcd_data == $past(cmd.d[1]);
	endproperty
	a_lcd: assert property (p_lcd) else $error("display write missing");
	property p_resp;
		@(posedge clk_sys) disable iff (!nrst)
		go ##1 1'b1 |-> resp.rtype[6] && resp.rtype[5:0] == $past(cmd.ctype[5:0]) &&
			(resp.rlen == 5'h00 || $past(cmd.ctype) == `HKF_CMD_POLL ||
			$past(cmd.ctype) == `HKF_CMD_FANQRY);
	endproperty
	a_resp: assert property (p_resp) else $error("answer type wrong");
	property p_rstmask;
		@(posedge clk_sys) $rose(nrst) |-> press_mask == 6'h3F && rel_mask == 6'h3F;
	endproperty
	a_rstmask: assert property (p_rstmask) else $error("key masks not all set");
	property p_poll;
		@(posedge clk_sys) disable iff (!nrst)
		go && next_poll |=> resp.rd[0][5:0] == $past(key_in) &&
			poll_press == ($past(key_in) & ~$past(key_prev));
	endproperty
	a_poll: assert property (p_poll) else $error("poll result wrong");
	property p_force;
		@(posedge clk_sys) disable iff (!nrst)
		fs_force && fs_mask[0] && !go ##1 fs_force |-> fan_pwm[0];
	endproperty
	a_force: assert property (p_force) else $error("fail-safe fan not at full power");
	property p_phase;
		@(posedge clk_sys) disable iff (!nrst) phase < 7'h64;
	endproperty
	a_phase: assert property (p_phase) else $error("phase out of range");
	property p_blank;
		@(posedge clk_sys) disable iff (!nrst) tach_ok[0] |-> $past(blank[0]) == 8'h00;
	endproperty
	a_blank: assert property (p_blank) else $error("tach taken while blanked");
	property p_atx;
		@(posedge clk_sys) disable iff (!nrst)
		$rose(atx_rst_oe) |-> atx_rst_o == $past(atx_mask[1]);
	endproperty
	a_atx: assert property (p_atx) else $error("reset line level wrong");
	property p_badfs;
		@(posedge clk_sys) disable iff (!nrst)
		go && cmd.ctype == `HKF_CMD_FAILSAFE && cmd.d[1] == 8'h00 |=> $stable(fs_timeout);
	endproperty
	a_badfs: assert property (p_badfs) else $error("bad timeout accepted");
endmodule // hkf_top

/* verif/hkf_far_side.sv */
// far-side model: fan tach lines and pulled-up power and reset lines
`timescale 1ns/1ps
module hkf_far_side (
	input wire logic clk_sys,
	input wire logic atx_rst_o,
	input wire logic atx_rst_oe,
	input wire logic atx_pwr_o,
	input wire logic atx_pwr_oe,
	output logic [3:0] tach_in,
	output logic atx_rst_i,
	output logic atx_pwr_i
);
	// tach noise runs even on unpowered fans
	initial tach_in = 4'h0;
	always @(posedge clk_sys) tach_in <= ~tach_in;
	// released lines float up to the pull-up
	assign atx_rst_i = atx_rst_oe ? atx_rst_o : 1'b1;
	assign atx_pwr_i = atx_pwr_oe ? atx_pwr_o : 1'b1;
endmodule // hkf_far_side

/* verif/hkf_top_bench.sv */
// self-checking bench of the command handler
`timescale 1ns/1ps
module hkf_top_bench;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, reboot = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [5:0] key_in = 6'h00;
	logic [31:0] prdata, rd, resp, r0, r1;
	logic pready, pslverr, lcd_wr, er;
	logic atx_rst_o, atx_rst_oe, atx_pwr_o, atx_pwr_oe, atx_rst_i, atx_pwr_i;
	logic [1:0] lcd_sel;
	logic [7:0] lcd_data;
	logic [3:0] fan_pwm, tach_ok, tach_in;
	logic [10:0] lcd_cap;
	int err_count = 0;
	int total_checks = 0;
	int cycles = 0;
	int hi [8];
	// rows: expected answer {len, type}, then command type, length, data
	logic [57:0] tab [13] = '{
		{13'h0057, 8'h17, 5'h02, 32'h00000401},
		{13'h00D7, 8'h17, 5'h03, 32'h00003F3F},
		{13'h00D8, 8'h18, 5'h01, 32'h00000000},
		{13'h00D9, 8'h19, 5'h02, 32'h00000510},
		{13'h00D9, 8'h19, 5'h02, 32'h00000001},
		{13'h005A, 8'h1A, 5'h04, 32'h01010101},
		{13'h00DA, 8'h1A, 5'h03, 32'h01010101},
		{13'h00D1, 8'h11, 5'h04, 32'h00000065},
		{13'h055B, 8'h1B, 5'h00, 32'h00000000},
		{13'h00DC, 8'h1C, 5'h03, 32'h00000000},
		{13'h005C, 8'h1C, 5'h02, 32'h00000202},
		{13'h0044, 8'h04, 5'h00, 32'h00000000},
		{13'h00F0, 8'h30, 5'h00, 32'h00000000}
	};

	hkf_top #(.STEP_CYC(4), .TICK8_CYC(8), .TICK32_CYC(4)) i_hkf_top (
		.clk_sys(clk_sys), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.key_in(key_in), .reboot(reboot), .tach_in(tach_in), .lcd_wr(lcd_wr),
		.lcd_sel(lcd_sel), .lcd_data(lcd_data), .fan_pwm(fan_pwm), .tach_ok(tach_ok),
		.atx_rst_i(atx_rst_i), .atx_rst_o(atx_rst_o), .atx_rst_oe(atx_rst_oe),
		.atx_pwr_i(atx_pwr_i), .atx_pwr_o(atx_pwr_o), .atx_pwr_oe(atx_pwr_oe)
	);
	hkf_far_side i_hkf_far_side (
		.clk_sys(clk_sys), .atx_rst_o(atx_rst_o), .atx_rst_oe(atx_rst_oe),
		.atx_pwr_o(atx_pwr_o), .atx_pwr_oe(atx_pwr_oe), .tach_in(tach_in),
		.atx_rst_i(atx_rst_i), .atx_pwr_i(atx_pwr_i)
	);

	always #25 clk_sys = ~clk_sys;

	task results();
		if (err_count == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 40000) begin
			err_count++;
			results();
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			err_count++;
		end
	endtask

	task apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
		@(posedge clk_sys);
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		psel <= 1'b1;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task cmd(input hkf_pkg::hkf_cmd_t c);
		apb(8'h00, 1'b1, {19'h0, c.clen, c.ctype});
		apb(8'h04, 1'b1, c.d);
		apb(8'h08, 1'b1, 32'h1);
		@(posedge clk_sys);
		lcd_cap = {lcd_wr, lcd_sel, lcd_data};
		apb(8'h0C, 1'b0, 32'h0);
		resp = rd;
		apb(8'h10, 1'b0, 32'h0);
		r0 = rd;
		apb(8'h14, 1'b0, 32'h0);
		r1 = rd;
	endtask

	task keys(input logic [5:0] v);
		key_in <= v;
		repeat (3) @(posedge clk_sys);
		key_in <= 6'h00;
		repeat (3) @(posedge clk_sys);
		apb(8'h18, 1'b0, 32'h0);
	endtask

	task pulse(input logic [31:0] v, input logic lvl, input int len);
		int n;
		n = 0;
		apb(8'h08, 1'b1, v);
		@(posedge clk_sys);
		chk(v[1] ? {atx_rst_oe, atx_rst_o, atx_rst_i, atx_pwr_oe, atx_pwr_i}
			: {atx_pwr_oe, atx_pwr_o, atx_pwr_i, atx_rst_oe, atx_rst_i},
			{1'b1, lvl, lvl, 2'b01});
		while ((atx_rst_oe | atx_pwr_oe) === 1'b1 && n < 2000) begin
			n++;
			@(posedge clk_sys);
		end
		chk(n >= len - 4 && n <= len + 1, 1);
	endtask

	task measure();
		hi = '{default: 0};
		repeat (400) begin
			@(posedge clk_sys);
			for (int i = 0; i < 4; i++) begin
				hi[i] += (fan_pwm[i] === 1'b1);
				hi[i + 4] += (tach_ok[i] === 1'b1);
			end
		end
	endtask

	initial begin
		repeat (20) @(posedge clk_sys);
		nrst <= 1'b1;
		apb(8'h08, 1'b0, 32'h0);
		chk(rd, 32'h18);
		apb(8'h1C, 1'b0, 32'h0);
		chk(er, 1);
		chk(rd, 0);
		apb(8'h20, 1'b1, 32'hFFFFFFFF);
		chk(er, 1);
		keys(6'h05);
		chk(rd, 32'h0505);
		pulse(32'h2, 1'b0, 128);
		for (int i = 0; i < 4; i++) begin
			cmd({8'h16, 5'h02, 16'h0, 8'hA0 + 8'(i), 8'(i)});
			chk(lcd_cap, (i < 3) ? {1'b1, 2'(i), 8'hA0 + 8'(i)} : {1'b0, 2'h2, 8'hA2});
			chk(resp, (i < 3) ? 32'h56 : 32'hD6);
		end
		for (int i = 0; i < 13; i++) begin
			cmd(hkf_pkg::hkf_cmd_t'(tab[i][44:0]));
			chk(resp, {19'h0, tab[i][57:45]});
		end
		keys(6'h07);
		chk(rd, 32'h0401);
		key_in <= 6'h20;
		repeat (3) @(posedge clk_sys);
		cmd({8'h18, 5'h00, 32'h0});
		chk(resp, 32'h0358);
		chk(r0, 32'h00072720);
		key_in <= 6'h00;
		repeat (3) @(posedge clk_sys);
		apb(8'h18, 1'b0, 32'h0);
		cmd({8'h17, 5'h02, 32'h00003F3F});
		cmd({8'h1C, 5'h01, 32'h0});
		pulse(32'h2, 1'b0, 8);
		reboot <= 1'b1;
		@(posedge clk_sys);
		reboot <= 1'b0;
		keys(6'h07);
		chk(rd, 32'h0401);
		pulse(32'h2, 1'b1, 8);
		cmd({8'h1C, 5'h01, 32'h4});
		pulse(32'h4, 1'b1, 8);
		cmd({8'h17, 5'h02, 32'h0});
		cmd({8'h11, 5'h04, 32'h00003200});
		measure();
		chk(hi[0], 0);
		chk(hi[1], 200);
		chk(hi[4], 0);
		cmd({8'h19, 5'h02, 32'h00000201});
		cmd({8'h1B, 5'h00, 32'h0});
		chk(r0, 32'h3200);
		chk(r1, 32'h01);
		repeat (40) @(posedge clk_sys);
		measure();
		chk(hi[0], 400);
		chk(hi[1], 200);
		chk(hi[5] > 0 && hi[5] < 100, 1);
		cmd({8'h1A, 5'h04, 32'h00003C01});
		// let a running on-phase end so the new delay is loaded at the next turn-on
		repeat (400) @(posedge clk_sys);
		measure();
		chk(hi[5], 0);
		chk(hi[4] > 0, 1);
		results();
	end
endmodule // hkf_top_bench
